// ### rtl/spbg_serial.sv
// Purpose: Serial port modes 0 and 1 with AHB-Lite registers and second-timer baud source.
// Assumes: mclk is the oscillator; timer_one_overflow is a one-cycle pulse on mclk.
// Notes: Line outputs are registered, so they follow internal state by one mclk cycle.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module spbg_serial (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Baud source from the first timer
  input wire logic timer_one_overflow,
  // Serial pins
  input wire logic port_line_zero_i,
  output logic port_line_zero_o,
  output logic port_line_zero_oe,
  output logic port_line_one_o,
  // External trigger pin of the second timer
  input wire logic external_trigger_input
);
  spbg_tmr_if tif ();

  spbg_timer u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tif(tif.tmr)
  );

  // Reception in mode 0 collects the first bit at the top, so it is reversed for LSB first.
  function automatic logic [7:0] spbg_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : spbg_rev8

  // Machine cycle phase counter.
  logic [3:0] ph_q, ph_d;
  logic at_s1p1, at_s5p2, at_s6p2;
  always_comb begin
    ph_d = (ph_q == spbg_pkg::PH_S6P2) ? 4'h0 : ph_q + 4'h1;
    at_s1p1 = ph_q == spbg_pkg::PH_S1P1;
    at_s5p2 = ph_q == spbg_pkg::PH_S5P2;
    at_s6p2 = ph_q == spbg_pkg::PH_S6P2;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q <= 4'h0;
    end else begin
      ph_q <= ph_d;
    end
  end

  // Pin synchronisers.
  logic [1:0] rxd_sync_q;
  logic [2:0] ext_sync_q;
  logic rxd;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_sync_q <= 2'b11;
      ext_sync_q <= 3'b111;
    end else begin
      rxd_sync_q <= {rxd_sync_q[0], port_line_zero_i};
      ext_sync_q <= {ext_sync_q[1:0], external_trigger_input};
    end
  end
  assign rxd = rxd_sync_q[1];

  // Bus slave: address phase captured, writes land in the data phase.
  logic wr_q, wr_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [7:0] rxbuf_q, rxbuf_d;
  logic take, wr_ctrl, wr_buf;
  always_comb begin
    take = hsel & hready & htrans[1];
    wr_d = take & hwrite;
    addr_d = take ? haddr[7:0] : addr_q;
    hrdata_d = hrdata_q;
    if (take & ~hwrite) begin
      case (haddr[7:0])
        spbg_pkg::OFF_CTRL: hrdata_d = {16'h0000, ctrl_q};
        spbg_pkg::OFF_BUF: hrdata_d = {24'h000000, rxbuf_q};
        spbg_pkg::OFF_RELOAD: hrdata_d = {16'h0000, tif.reload};
        spbg_pkg::OFF_TIMER: hrdata_d = {16'h0000, tif.count};
        default: hrdata_d = 32'h00000000;
      endcase
    end
    wr_ctrl = wr_q & (addr_q == spbg_pkg::OFF_CTRL);
    wr_buf = wr_q & (addr_q == spbg_pkg::OFF_BUF);
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_q <= wr_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Timer wiring and baud source selection.
  logic mode0, tx_tick, rx_tick;
  always_comb begin
    mode0 = ~ctrl_q[spbg_pkg::B_MODE];
    tif.run = ctrl_q[spbg_pkg::B_TR2];
    tif.baud_mode = ctrl_q[spbg_pkg::B_TX_CLOCK_SELECT] | ctrl_q[spbg_pkg::B_RCLK];
    tif.ext_enable = ctrl_q[spbg_pkg::B_EXTERNAL_TRIGGER_ENABLE];
    tif.ext_fall = ext_sync_q[2] & ~ext_sync_q[1];
    tif.state_tick = ph_q[0];
    tif.cycle_tick = at_s6p2;
    tif.wr_timer = wr_q & (addr_q == spbg_pkg::OFF_TIMER);
    tif.wr_reload = wr_q & (addr_q == spbg_pkg::OFF_RELOAD);
    tif.wdata = hwdata[15:0];
    tx_tick = ctrl_q[spbg_pkg::B_TX_CLOCK_SELECT] ? tif.roll : timer_one_overflow;
    rx_tick = ctrl_q[spbg_pkg::B_RCLK] ? tif.roll : timer_one_overflow;
  end

  // Transmitter for both modes.
  spbg_pkg::spbg_tx_e tx_q, tx_d;
  logic [8:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_div_q, tx_div_d;
  logic tx_roll, tx_step, ti_set;
  always_comb begin
    tx_d = tx_q;
    tx_sh_d = tx_sh_q;
    ti_set = 1'b0;
    tx_div_d = tx_tick ? tx_div_q + 4'h1 : tx_div_q;
    tx_roll = tx_tick & (tx_div_q == spbg_pkg::DIV_LAST);
    tx_step = mode0 ? at_s6p2 : tx_roll;
    if (wr_buf) begin
      tx_sh_d = {1'b1, hwdata[7:0]};
      tx_d = spbg_pkg::TX_PEND;
    end else begin
      case (tx_q)
        spbg_pkg::TX_PEND: begin
          if (mode0 ? at_s1p1 : tx_roll) begin
            tx_d = spbg_pkg::TX_START;
          end
        end
        spbg_pkg::TX_START: begin
          if (tx_step) begin
            tx_d = spbg_pkg::TX_DATA;
          end
        end
        spbg_pkg::TX_DATA: begin
          if (tx_step) begin
            tx_sh_d = {1'b0, tx_sh_q[8:1]};
            if (tx_sh_q[8:1] == spbg_pkg::TX_LAST_PAT) begin
              if (mode0) begin
                tx_d = spbg_pkg::TX_END;
              end else begin
                tx_d = spbg_pkg::TX_IDLE;
                ti_set = 1'b1;
              end
            end
          end
        end
        spbg_pkg::TX_END: begin
          if (at_s1p1) begin
            tx_d = spbg_pkg::TX_IDLE;
            ti_set = 1'b1;
          end
        end
        default: tx_d = spbg_pkg::TX_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q <= spbg_pkg::TX_IDLE;
      tx_sh_q <= spbg_pkg::TX_RST;
      tx_div_q <= 4'h0;
    end else begin
      tx_q <= tx_d;
      tx_sh_q <= tx_sh_d;
      tx_div_q <= tx_div_d;
    end
  end

  // Receiver for both modes.
  spbg_pkg::spbg_rx_e rx_q, rx_d;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic [3:0] rx_div_q, rx_div_d, rx_cnt_q, rx_cnt_d;
  logic rx_prev_q, rx_prev_d, samp_q, samp_d;
  logic start1, mid, ri_set, rb8_set, rb8_val;
  always_comb begin
    rx_d = rx_q;
    rx_sh_d = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    rxbuf_d = rxbuf_q;
    ri_set = 1'b0;
    rb8_set = 1'b0;
    rb8_val = 1'b0;
    rx_prev_d = rx_tick ? rxd : rx_prev_q;
    samp_d = at_s5p2 ? rxd : samp_q;
    start1 = ~mode0 & (rx_q == spbg_pkg::RX_IDLE) & ctrl_q[spbg_pkg::B_REN] & rx_tick
           & rx_prev_q & ~rxd;
    mid = rx_tick & (rx_div_q == spbg_pkg::DIV_MID);
    rx_div_d = start1 ? 4'h0 : (rx_tick ? rx_div_q + 4'h1 : rx_div_q);
    case (rx_q)
      spbg_pkg::RX_IDLE: begin
        if (mode0 & ctrl_q[spbg_pkg::B_REN] & ~ctrl_q[spbg_pkg::B_RI]) begin
          rx_d = spbg_pkg::RX_ARM;
        end else if (start1) begin
          rx_d = spbg_pkg::RX_HUNT;
          rx_sh_d = spbg_pkg::RX1_INIT;
          rx_cnt_d = 4'h0;
        end
      end
      spbg_pkg::RX_ARM: begin
        if (at_s1p1) begin
          rx_d = spbg_pkg::RX_WAIT;
        end
      end
      spbg_pkg::RX_WAIT: begin
        if (at_s6p2) begin
          rx_sh_d = spbg_pkg::RX0_INIT;
          rx_d = spbg_pkg::RX_RECV;
        end
      end
      spbg_pkg::RX_RECV: begin
        if (at_s6p2) begin
          rx_sh_d = {rx_sh_q[7:0], samp_q};
          if (~rx_sh_q[7]) begin
            rxbuf_d = spbg_rev8({rx_sh_q[6:0], samp_q});
            rx_d = spbg_pkg::RX_FIN;
          end
        end
      end
      spbg_pkg::RX_FIN: begin
        if (at_s1p1) begin
          rx_d = spbg_pkg::RX_IDLE;
          ri_set = 1'b1;
        end
      end
      spbg_pkg::RX_HUNT: begin
        if (mid) begin
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == 4'h0) begin
            if (rxd) begin
              rx_d = spbg_pkg::RX_IDLE;
            end
          end else begin
            rx_sh_d = {rxd, rx_sh_q[8:1]};
            if (rx_cnt_q == spbg_pkg::RX1_LAST) begin
              rx_d = spbg_pkg::RX_IDLE;
              if (~ctrl_q[spbg_pkg::B_RI]) begin
                rxbuf_d = rx_sh_q[8:1];
                rb8_set = 1'b1;
                rb8_val = rxd;
                ri_set = 1'b1;
              end
            end
          end
        end
      end
      default: rx_d = spbg_pkg::RX_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_q <= spbg_pkg::RX_IDLE;
      rx_sh_q <= spbg_pkg::RX1_INIT;
      rx_div_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_prev_q <= 1'b1;
      samp_q <= 1'b1;
      rxbuf_q <= 8'h00;
    end else begin
      rx_q <= rx_d;
      rx_sh_q <= rx_sh_d;
      rx_div_q <= rx_div_d;
      rx_cnt_q <= rx_cnt_d;
      rx_prev_q <= rx_prev_d;
      samp_q <= samp_d;
      rxbuf_q <= rxbuf_d;
    end
  end

  // Control register: hardware setting a flag wins over a software clear.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = (hwdata[15:0] & spbg_pkg::CTRL_WMASK) | (ctrl_q & ~spbg_pkg::CTRL_WMASK);
    end
    if (ti_set) begin
      ctrl_d[spbg_pkg::B_TI] = 1'b1;
    end
    if (ri_set) begin
      ctrl_d[spbg_pkg::B_RI] = 1'b1;
    end
    if (rb8_set) begin
      ctrl_d[spbg_pkg::B_RB8] = rb8_val;
    end
    if (tif.ovf_set) begin
      ctrl_d[spbg_pkg::B_TF2] = 1'b1;
    end
    if (tif.ext_set) begin
      ctrl_d[spbg_pkg::B_EXTERNAL_TRIGGER_FLAG] = 1'b1;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= spbg_pkg::CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Registered line drivers.
  logic line0_q, line0_d, line0_oe_q, line0_oe_d, line1_q, line1_d;
  logic sclk, send0, recv0;
  always_comb begin
    sclk = ~((ph_q >= spbg_pkg::PH_S3P1) && (ph_q < spbg_pkg::PH_S6P1));
    send0 = mode0 & ((tx_q == spbg_pkg::TX_DATA) | (tx_q == spbg_pkg::TX_END));
    recv0 = mode0 & (rx_q == spbg_pkg::RX_RECV);
    if (mode0) begin
      line1_d = (send0 | recv0) ? sclk : 1'b1;
    end else if (tx_q == spbg_pkg::TX_START) begin
      line1_d = 1'b0;
    end else if (tx_q == spbg_pkg::TX_DATA) begin
      line1_d = tx_sh_q[0];
    end else begin
      line1_d = 1'b1;
    end
    line0_d = tx_sh_q[0];
    line0_oe_d = send0;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      line0_q <= 1'b1;
      line0_oe_q <= 1'b0;
      line1_q <= 1'b1;
    end else begin
      line0_q <= line0_d;
      line0_oe_q <= line0_oe_d;
      line1_q <= line1_d;
    end
  end
  assign port_line_zero_o = line0_q;
  assign port_line_zero_oe = line0_oe_q;
  assign port_line_one_o = line1_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_tx0_sclk;
    send0 && ph_q == spbg_pkg::PH_S3P1 |=> !port_line_one_o [*6];
  endproperty
  a_tx0_sclk: assert property (p_tx0_sclk) else $error("shift clock not low");
  property p_tx0_done;
    tx_q == spbg_pkg::TX_END && at_s1p1 && !wr_buf
      |=> ctrl_q[spbg_pkg::B_TI] && tx_q == spbg_pkg::TX_IDLE;
  endproperty
  a_tx0_done: assert property (p_tx0_done) else $error("transmit end wrong");
  property p_rx0_load;
    rx_q == spbg_pkg::RX_WAIT && at_s6p2
      |=> rx_sh_q == spbg_pkg::RX0_INIT && rx_q == spbg_pkg::RX_RECV;
  endproperty
  a_rx0_load: assert property (p_rx0_load) else $error("receive preload wrong");
  property p_rx1_start;
    start1 |=> rx_div_q == 4'h0 && rx_sh_q == spbg_pkg::RX1_INIT;
  endproperty
  a_rx1_start: assert property (p_rx1_start) else $error("start alignment wrong");
  property p_tx1_start;
    !mode0 && tx_q == spbg_pkg::TX_START |=> !port_line_one_o;
  endproperty
  a_tx1_start: assert property (p_tx1_start) else $error("start bit not low");
  property p_baud_no_tf2;
    tif.baud_mode && !ctrl_q[spbg_pkg::B_TF2] && !wr_ctrl |=> !ctrl_q[spbg_pkg::B_TF2];
  endproperty
  a_baud_no_tf2: assert property (p_baud_no_tf2) else $error("flag set in baud mode");
  c_tx0: cover property (tx_q == spbg_pkg::TX_END && at_s1p1);
  c_rx0: cover property (rx_q == spbg_pkg::RX_FIN && at_s1p1);
  c_rx1: cover property (rb8_set);
endmodule : spbg_serial

// ### pkg/spbg_pkg.sv
// Purpose: Shared constants and types for the serial port and second-timer baud generator.
// Assumes: One mclk cycle stands for one oscillator period; twelve phases make a machine cycle.
// Notes: The rules of the block are listed below.
// How it works
// - Either clock select bit puts the second timer into baud generator mode.
// - In baud mode a timer rollover reloads it from the 16-bit reload value.
// - In baud mode the timer counts every state time, otherwise once per machine cycle.
// - In baud mode a rollover neither sets the overflow flag nor raises an interrupt.
// - In baud mode an enabled trigger falling edge sets its flag but never reloads.
// - Mode 0 moves eight bits LSB first on line zero, line one is the clock.
// - Mode 0 buffer write loads marker and data; send starts a full cycle later.
// - Mode 0 send drives data out; clock low in S3 to S5, else high.
// - Mode 0 transmit shifts right at S6P2 while sending, zeros enter from left.
// - Mode 0 after marker reaches output side: last shift, then stop and flag at S1P1.
// - Mode 0 receive starts on enable with flag clear; loads 11111110, then receives.
// - Mode 0 receive clock toggles S3P1 and S6P1; shift left at S6P2 sampled S5P2.
// - Mode 0 when the zero reaches the top, load buffer, then stop and flag.
// - Mode 1 frame: start zero, eight data bits LSB first, stop one into ninth bit.
// - Mode 1 rate comes from first or second timer overflow, per direction.
// - Mode 1 buffer write loads marker; sending starts after next divide-by-16 rollover.
// - Mode 1 sends start bit, data one bit later, first shift one bit after that.
// - Mode 1 after marker reaches output side: last shift, stop send, set flag.
// - Mode 1 receive starts on a falling edge sampled at sixteen times bit rate.
// - On the start edge the receive divider resets and shift register takes 1FFH.
// - Transmit and receive clock sources are selected independently.
package spbg_pkg;
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S3P1 = 4'h4;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P1 = 4'ha;
  localparam logic [3:0] PH_S6P2 = 4'hb;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BUF = 8'h04;
  localparam logic [7:0] OFF_RELOAD = 8'h08;
  localparam logic [7:0] OFF_TIMER = 8'h0c;
  localparam int B_MODE = 0;
  localparam int B_REN = 1;
  localparam int B_TI = 2;
  localparam int B_RI = 3;
  localparam int B_RB8 = 4;
  localparam int B_TX_CLOCK_SELECT = 8;
  localparam int B_RCLK = 9;
  localparam int B_TR2 = 10;
  localparam int B_EXTERNAL_TRIGGER_ENABLE = 11;
  localparam int B_TF2 = 12;
  localparam int B_EXTERNAL_TRIGGER_FLAG = 13;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h3f0f;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam logic [15:0] TMR_MAX = 16'hffff;
  localparam logic [8:0] TX_RST = 9'h1ff;
  localparam logic [7:0] TX_LAST_PAT = 8'h01;
  localparam logic [8:0] RX0_INIT = 9'h0fe;
  localparam logic [8:0] RX1_INIT = 9'h1ff;
  localparam logic [3:0] DIV_LAST = 4'hf;
  localparam logic [3:0] DIV_MID = 4'h7;
  localparam logic [3:0] RX1_LAST = 4'h9;
  typedef enum logic [2:0] {TX_IDLE, TX_PEND, TX_START, TX_DATA, TX_END} spbg_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_ARM, RX_WAIT, RX_RECV, RX_FIN, RX_HUNT} spbg_rx_e;
endpackage : spbg_pkg

// ### pkg/spbg_tmr_if.sv
// Purpose: Carries control and status between the serial logic and the second timer.
// Assumes: All signals are on mclk.
// Notes: Ticks and strobes are one-cycle pulses.
`timescale 1ns/10ps
interface spbg_tmr_if;
  logic run;
  logic baud_mode;
  logic ext_enable;
  logic ext_fall;
  logic state_tick;
  logic cycle_tick;
  logic wr_timer;
  logic wr_reload;
  logic [15:0] wdata;
  logic [15:0] count;
  logic [15:0] reload;
  logic roll;
  logic ovf_set;
  logic ext_set;
  modport tmr (input run, baud_mode, ext_enable, ext_fall, state_tick, cycle_tick,
               wr_timer, wr_reload, wdata, output count, reload, roll, ovf_set, ext_set);
  modport ctl (output run, baud_mode, ext_enable, ext_fall, state_tick, cycle_tick,
               wr_timer, wr_reload, wdata, input count, reload, roll, ovf_set, ext_set);
endinterface : spbg_tmr_if

// ### rtl/spbg_timer.sv
// Purpose: Second timer with auto-reload and baud generator behaviour.
// Assumes: Software stops the timer before writing the count or reload value.
// Notes: Roll is the baud overflow pulse used by the serial logic.
`timescale 1ns/10ps
module spbg_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial logic side
  spbg_tmr_if.tmr tif
);
  logic [15:0] count_q, count_d, reload_q, reload_d;
  logic inc;

  always_comb begin
    inc = tif.run & (tif.baud_mode ? tif.state_tick : tif.cycle_tick);
    tif.roll = inc & (count_q == spbg_pkg::TMR_MAX);
    tif.ovf_set = tif.roll & ~tif.baud_mode;
    tif.ext_set = tif.ext_enable & tif.ext_fall;
    count_d = count_q;
    reload_d = reload_q;
    if (tif.wr_reload) begin
      reload_d = tif.wdata;
    end
    if (tif.wr_timer) begin
      count_d = tif.wdata;
    end else if (tif.roll) begin
      count_d = reload_q;
    end else if (~tif.baud_mode & tif.ext_enable & tif.ext_fall) begin
      count_d = reload_q;
    end else if (inc) begin
      count_d = count_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= spbg_pkg::TMR_RST;
      reload_q <= spbg_pkg::TMR_RST;
    end else begin
      count_q <= count_d;
      reload_q <= reload_d;
    end
  end

  assign tif.count = count_q;
  assign tif.reload = reload_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_baud_reload;
    tif.baud_mode && tif.roll && !tif.wr_timer |=> count_q == $past(reload_q);
  endproperty
  a_baud_reload: assert property (p_baud_reload) else $error("baud reload missed");
  property p_state_rate;
    tif.baud_mode && tif.run && tif.state_tick && !tif.roll && !tif.wr_timer
      |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_state_rate: assert property (p_state_rate) else $error("baud count rate wrong");
  property p_no_ovf;
    tif.baud_mode && tif.roll |-> !tif.ovf_set;
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("overflow flag set in baud mode");
  property p_ext_no_reload;
    tif.baud_mode && tif.ext_enable && tif.ext_fall && !inc && !tif.wr_timer
      |-> tif.ext_set ##1 $stable(count_q);
  endproperty
  a_ext_no_reload: assert property (p_ext_no_reload) else $error("trigger reloaded");
  c_baud_roll: cover property (tif.baud_mode && tif.roll);
endmodule : spbg_timer

// ### bench/spbg_peer.sv
// Purpose: Behavioural far-side serial peer for modes 0 and 1.
// Assumes: A mode 1 bit lasts a whole number of mclk cycles, given by the caller.
// Notes: After a mode 0 byte the released line shows the inverse of its last bit.
`timescale 1ns/10ps
module spbg_peer (
  // Clock
  input wire logic mclk,
  // Line side
  input wire logic shift_clk,
  input wire logic data_o,
  input wire logic data_oe,
  output logic data_i
);
  logic [7:0] m0_cap = 8'h00;
  logic [7:0] m0_src = 8'h00;
  int m0_cnt = 0;
  int m0_left = 0;
  initial begin
    data_i = 1'b1;
  end
  always @(posedge shift_clk) begin
    if (data_oe) begin
      m0_cap = {data_o, m0_cap[7:1]};
      m0_cnt++;
    end
    if (m0_left > 0) begin
      m0_left--;
      m0_src = m0_src >> 1;
      data_i = (m0_left == 0) ? ~data_i : m0_src[0];
    end
  end
  task automatic m0_load(input logic [7:0] b);
    m0_src = b;
    m0_left = 8;
    data_i = b[0];
  endtask : m0_load
  task automatic m1_put(input logic [7:0] b, input int bt);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    data_i <= 1'b1;
    repeat (2 * bt) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      data_i <= fr[i];
      repeat (bt) @(posedge mclk);
    end
  endtask : m1_put
  task automatic m1_get(input int bt, output logic [9:0] fr);
    int n;
    n = 0;
    while (shift_clk !== 1'b0 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    repeat (bt / 2) @(negedge mclk);
    for (int i = 0; i < 10; i++) begin
      fr[i] = shift_clk;
      repeat (bt) @(negedge mclk);
    end
  endtask : m1_get
endmodule : spbg_peer

// ### bench/tb_serial_port_shift_and_async_baud_gen.sv
// Purpose: Self-checking bench for the serial port and second-timer baud generator.
// Assumes: Timer one overflows every 8 mclk, so a mode 1 bit lasts 128 mclk.
// Notes: A reload of fffc makes the second timer give the same bit time.
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("[FAIL] %s exp %0h got %0h", nm, exp, got); \
  end
module tb_serial_port_shift_and_async_baud_gen;
  logic mclk;
  logic sys_rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic timer_one_overflow = 1'b0;
  logic [2:0] t1_div = 3'h0;
  logic port_line_zero_i;
  logic port_line_zero_o;
  logic port_line_zero_oe;
  logic port_line_one_o;
  logic external_trigger_input;
  logic [31:0] v;
  logic [31:0] t;
  logic [31:0] dummy;
  logic [9:0] f;
  int err_total;
  int num_checks;
  spbg_serial i_spbg_serial (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_one_overflow(timer_one_overflow), .port_line_zero_i(port_line_zero_i),
    .port_line_zero_o(port_line_zero_o), .port_line_zero_oe(port_line_zero_oe),
    .port_line_one_o(port_line_one_o), .external_trigger_input(external_trigger_input));
  spbg_peer i_spbg_peer (.mclk(mclk), .shift_clk(port_line_one_o), .data_o(port_line_zero_o),
    .data_oe(port_line_zero_oe), .data_i(port_line_zero_i));
  always #20 mclk = ~mclk;
  // Timer one overflow runs freely as the 320 ns link tick.
  always @(posedge mclk) begin
    t1_div <= t1_div + 3'h1;
    timer_one_overflow <= (t1_div == 3'h7);
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic edge_wait();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      stop_test();
    end
  endtask : edge_wait
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    edge_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_wait();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, dummy);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(a, 1'b0, 32'h0, r);
  endtask : rd
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      rd(spbg_pkg::OFF_CTRL, v);
      n++;
    end while (v[b] !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      err_total++;
      stop_test();
    end
  endtask : wait_flag
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    external_trigger_input = 1'b1;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(spbg_pkg::OFF_CTRL, v);
    `CHK("ctrl_reset", {16'h0, spbg_pkg::CTRL_RST}, v)
    `CHK("hresp_okay", 1'b0, hresp)
    wr(8'h10, 32'hffffffff);
    rd(8'h10, v);
    `CHK("unmapped", 32'h0, v)
    wr(spbg_pkg::OFF_CTRL, 32'hffffffff);
    rd(spbg_pkg::OFF_CTRL, v);
    `CHK("ctrl_mask", {16'h0, spbg_pkg::CTRL_WMASK}, v)
    wr(spbg_pkg::OFF_CTRL, 32'h0);
    wr(spbg_pkg::OFF_BUF, 32'ha5);
    wait_flag(spbg_pkg::B_TI);
    `CHK("m0_tx_byte", 8'ha5, i_spbg_peer.m0_cap)
    `CHK("m0_tx_bits", 8, i_spbg_peer.m0_cnt)
    `CHK("m0_tx_oe", 1'b0, port_line_zero_oe)
    i_spbg_peer.m0_load(8'h3c);
    wr(spbg_pkg::OFF_CTRL, 32'h2);
    wait_flag(spbg_pkg::B_RI);
    rd(spbg_pkg::OFF_BUF, v);
    `CHK("m0_rx_byte", 32'h3c, v)
    wr(spbg_pkg::OFF_CTRL, 32'h0);
    wr(spbg_pkg::OFF_RELOAD, 32'hff00);
    wr(spbg_pkg::OFF_TIMER, 32'hfff0);
    wr(spbg_pkg::OFF_CTRL, 32'h0600);
    repeat (240) @(posedge mclk);
    wr(spbg_pkg::OFF_CTRL, 32'h0200);
    rd(spbg_pkg::OFF_TIMER, v);
    `CHK("baud_count", 1'b1, v inside {[32'hff68:32'hff6a]})
    rd(spbg_pkg::OFF_CTRL, v);
    `CHK("baud_no_ovf", 1'b0, v[spbg_pkg::B_TF2])
    wr(spbg_pkg::OFF_TIMER, 32'h0);
    wr(spbg_pkg::OFF_CTRL, 32'h0400);
    repeat (240) @(posedge mclk);
    wr(spbg_pkg::OFF_CTRL, 32'h0a00);
    rd(spbg_pkg::OFF_TIMER, t);
    `CHK("cycle_count", 1'b1, t inside {[32'h14:32'h15]})
    external_trigger_input <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(spbg_pkg::OFF_CTRL, v);
    `CHK("trig_flag", 1'b1, v[spbg_pkg::B_EXTERNAL_TRIGGER_FLAG])
    rd(spbg_pkg::OFF_TIMER, v);
    `CHK("trig_no_reload", t, v)
    external_trigger_input <= 1'b1;
    wr(spbg_pkg::OFF_CTRL, 32'h0);
    wr(spbg_pkg::OFF_RELOAD, 32'hfffc);
    wr(spbg_pkg::OFF_TIMER, 32'hfffc);
    wr(spbg_pkg::OFF_CTRL, 32'h0603);
    fork
      wr(spbg_pkg::OFF_BUF, 32'hc3);
      i_spbg_peer.m1_get(128, f);
      i_spbg_peer.m1_put(8'h5a, 128);
    join
    wait_flag(spbg_pkg::B_RI);
    `CHK("m1_tx_flag", 1'b1, v[spbg_pkg::B_TI])
    `CHK("m1_stop_bit", 1'b1, v[spbg_pkg::B_RB8])
    `CHK("m1_no_ovf", 1'b0, v[spbg_pkg::B_TF2])
    `CHK("m1_tx_frame", {1'b1, 8'hc3, 1'b0}, f)
    rd(spbg_pkg::OFF_BUF, v);
    `CHK("m1_rx_byte", 32'h5a, v)
    wr(spbg_pkg::OFF_CTRL, 32'h0701);
    fork
      wr(spbg_pkg::OFF_BUF, 32'h96);
      i_spbg_peer.m1_get(128, f);
    join
    `CHK("m1_t2_frame", {1'b1, 8'h96, 1'b0}, f)
    rd(spbg_pkg::OFF_CTRL, v);
    `CHK("m1_t2_flag", 1'b1, v[spbg_pkg::B_TI])
    stop_test();
  end
endmodule : tb_serial_port_shift_and_async_baud_gen
